// ===== logic/lhb_host_if.sv
// Host-side bus port of the display controller: 8080, 6800 and serial.
// Assumes all pins are asynchronous to clk and that the pad cell
// resolves host_bus from host_bus_o and host_bus_oe.
//
// Behaviour
// - Transfers count only while chip_sel_n low and chip_sel_hi high.
// - hw_init_n low returns every internal setting to its initial value.
// - data_cmd_sel high marks display data, low marks a command byte.
// - In 8080 mode the bus is captured on the write strobe rising edge.
// - In 8080 mode the bus is driven while the read strobe is low.
// - In 6800 mode the write pin selects direction: high read, low write.
// - In 6800 mode the read pin is an active-high enable strobe.
// - Parallel mode exchanges bytes over an 8-bit bidirectional bus.
// - Serial mode: data on line 7, clock on line 6, write only.
// - Serial mode keeps data lines 0 to 5 undriven.
// - With chip select inactive all eight data lines are undriven.
// - bus_style_sel high picks 6800 style, low picks 8080 style.
// - par_ser_sel high picks parallel, low picks serial write-only.
// - Command byte E2h resets the controller's internal functions.
// - Command byte E3h is accepted and does nothing.
// - Status read gives status in upper bits, lower four bits zero.
`default_nettype none

module lhb_host_if
    import lhb_pkg::*;
#(
    parameter int DATA_W = 8
) (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Host pins
    input wire logic chip_sel_n,
    input wire logic chip_sel_hi,
    input wire logic hw_init_n,
    input wire logic data_cmd_sel,
    input wire logic wr_strobe_n,
    input wire logic rd_strobe_n,
    input wire logic bus_style_sel,
    input wire logic par_ser_sel,
    input wire logic [7:0] host_bus_i,
    output logic [7:0] host_bus_o,
    output logic [7:0] host_bus_oe,
    // Controller core side
    input wire logic [3:0] status_in,
    input wire logic [7:0] rd_data_in,
    output logic wr_valid,
    output logic [7:0] wr_data,
    output logic wr_is_data,
    output logic rd_done,
    output logic ctrl_init
);

    if (DATA_W != LHB_BUS_W) begin : g_bad_width
        $error("lhb_host_if: DATA_W must be 8");
    end

    // ------------------------------------------------------------
    // Mode decode
    // ------------------------------------------------------------
    function automatic lhb_mode_type mode_of(input logic style, input logic par);
        lhb_mode_type m;
        m = LHB_M8080;
        if (!par) begin
            m = LHB_MSER;
        end else if (style) begin
            m = LHB_M6800;
        end
        return m;
    endfunction : mode_of

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    // Three stages; a change is taken once stages two and three agree,
    // which also rejects single-cycle glitches on slow host edges.
    logic [15:0] raw;
    logic [15:0] s1_q, s1_d, s2_q, s2_d, s3_q, s3_d, f_q, f_d;
    lhb_pins_type pf;

    assign raw = {chip_sel_n, chip_sel_hi, hw_init_n, data_cmd_sel,
                  wr_strobe_n, rd_strobe_n, bus_style_sel, par_ser_sel,
                  host_bus_i};
    assign pf = f_q;

    always_comb begin
        s1_d = raw;
        s2_d = s1_q;
        s3_d = s2_q;
    end

    for (genvar i = 0; i < 16; i++) begin : g_filt
        assign f_d[i] = (s2_q[i] == s3_q[i]) ? s2_q[i] : f_q[i];
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s1_q <= LHB_PINS_IDLE;
            s2_q <= LHB_PINS_IDLE;
            s3_q <= LHB_PINS_IDLE;
            f_q <= LHB_PINS_IDLE;
        end else begin
            s1_q <= s1_d;
            s2_q <= s2_d;
            s3_q <= s3_d;
            f_q <= f_d;
        end
    end

    // ------------------------------------------------------------
    // Strobe decode
    // ------------------------------------------------------------
    lhb_mode_type mode;
    logic cs_act, live;
    logic w8080, w6800, par_wr, rd_act, scl_rise, ser_done;
    logic prev_wr_q, prev_rd_q, prev_scl_q, rd_act_q;
    logic prev_wr_d, prev_rd_d, prev_scl_d, rd_act_d;

    assign mode = mode_of(pf.style, pf.par);
    assign cs_act = !pf.cs_n && pf.cs_hi;
    // nothing is taken while held in init
    assign live = cs_act && pf.init_n;
    assign w8080 = (mode == LHB_M8080) && live && pf.wr && !prev_wr_q;
    // write pin low means write; enable falling edge ends it
    assign w6800 = (mode == LHB_M6800) && live && !pf.wr && prev_rd_q && !pf.rd;
    assign par_wr = w8080 || w6800;
    // 8080 read while strobe low; 6800 read with enable high
    assign rd_act = live && (((mode == LHB_M8080) && !pf.rd)
                    || ((mode == LHB_M6800) && pf.wr && pf.rd));
    assign scl_rise = (mode == LHB_MSER) && live && pf.bus[LHB_SCL_BIT] && !prev_scl_q;

    always_comb begin
        prev_wr_d = pf.wr;
        prev_rd_d = pf.rd;
        prev_scl_d = pf.bus[LHB_SCL_BIT];
        rd_act_d = rd_act;
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            prev_wr_q <= 1'b1;
            prev_rd_q <= 1'b1;
            prev_scl_q <= 1'b1;
            rd_act_q <= 1'b0;
        end else begin
            prev_wr_q <= prev_wr_d;
            prev_rd_q <= prev_rd_d;
            prev_scl_q <= prev_scl_d;
            rd_act_q <= rd_act_d;
        end
    end

    // ------------------------------------------------------------
    // Serial shifter
    // ------------------------------------------------------------
    logic [6:0] shift_q, shift_d;
    logic [2:0] cnt_q, cnt_d;

    assign ser_done = scl_rise && (cnt_q == LHB_SER_LAST);

    always_comb begin
        shift_d = shift_q;
        cnt_d = cnt_q;
        // Deselect aborts a partial byte so the next frame starts aligned
        if (!live || (mode != LHB_MSER)) begin
            cnt_d = 3'h0;
        end else if (scl_rise) begin
            shift_d = {shift_q[5:0], pf.bus[LHB_SI_BIT]};
            cnt_d = cnt_q + 3'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            shift_q <= 7'h00;
            cnt_q <= 3'h0;
        end else begin
            shift_q <= shift_d;
            cnt_q <= cnt_d;
        end
    end

    // ------------------------------------------------------------
    // Byte dispatch and bus drive
    // ------------------------------------------------------------
    logic new_byte, is_reset, is_nop;
    logic [7:0] byte_val;
    logic wr_valid_q, wr_valid_d, wr_is_data_q, wr_is_data_d;
    logic rd_done_q, rd_done_d, ctrl_init_q, ctrl_init_d;
    logic [7:0] wr_data_q, wr_data_d, out_q, out_d, oe_q, oe_d;

    assign new_byte = par_wr || ser_done;
    // full byte from the parallel bus, or seven shifted bits plus the current serial data bit
    assign byte_val = par_wr ? pf.bus : {shift_q, pf.bus[LHB_SI_BIT]};
    assign is_reset = !pf.dc && (byte_val == LHB_CMD_RESET);
    assign is_nop = !pf.dc && (byte_val == LHB_CMD_NOP);

    always_comb begin
        wr_valid_d = new_byte && !is_reset && !is_nop;
        wr_data_d = new_byte ? byte_val : wr_data_q;
        wr_is_data_d = new_byte ? pf.dc : wr_is_data_q;
        ctrl_init_d = !pf.init_n || (new_byte && is_reset);
        rd_done_d = rd_act_q && !rd_act && pf.dc;
        out_d = out_q;
        oe_d = LHB_OE_NONE;
        // deselect floats the bus; serial never drives
        if (rd_act) begin
            oe_d = LHB_OE_ALL;
            // status in upper bits, low bits zero
            out_d = pf.dc ? rd_data_in : {status_in, LHB_STAT_LOW};
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            wr_valid_q <= 1'b0;
            wr_data_q <= LHB_BYTE_RST;
            wr_is_data_q <= 1'b0;
            ctrl_init_q <= 1'b0;
            rd_done_q <= 1'b0;
            out_q <= LHB_BYTE_RST;
            oe_q <= LHB_OE_NONE;
        end else begin
            wr_valid_q <= wr_valid_d;
            wr_data_q <= wr_data_d;
            wr_is_data_q <= wr_is_data_d;
            ctrl_init_q <= ctrl_init_d;
            rd_done_q <= rd_done_d;
            out_q <= out_d;
            oe_q <= oe_d;
        end
    end

    assign wr_valid = wr_valid_q;
    assign wr_data = wr_data_q;
    assign wr_is_data = wr_is_data_q;
    assign ctrl_init = ctrl_init_q;
    assign rd_done = rd_done_q;
    assign host_bus_o = out_q;
    assign host_bus_oe = oe_q;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    chk_cs_blocks_wr: assert property (!cs_act |=> !wr_valid)
        else $error("write accepted while deselected");
    chk_init_level: assert property (!pf.init_n |=> ctrl_init && !wr_valid)
        else $error("hardware init not applied");
    chk_dc_tags_byte: assert property (new_byte && pf.dc |=> wr_valid && wr_is_data)
        else $error("data byte not tagged as data");
    chk_wr_capture: assert property (w8080 && pf.dc |=> wr_data == $past(pf.bus))
        else $error("8080 write byte mismatch");
    chk_rd_drive: assert property ((mode == LHB_M8080) && live && !pf.rd
        |=> host_bus_oe == LHB_OE_ALL)
        else $error("8080 read does not drive bus");
    chk_6800_read: assert property ((mode == LHB_M6800) && live && pf.wr && pf.rd
        |=> host_bus_oe == LHB_OE_ALL)
        else $error("6800 read does not drive bus");
    chk_6800_write: assert property (w6800 && pf.dc |=> wr_valid && !$past(pf.wr))
        else $error("6800 write not taken");
    chk_serial_float: assert property ((mode == LHB_MSER) |=> host_bus_oe == LHB_OE_NONE)
        else $error("serial mode drives bus");
    chk_serial_byte: assert property (ser_done && pf.dc |=> wr_valid ##1 !wr_valid)
        else $error("serial byte not delivered once");
    chk_oe_cs_off: assert property (!cs_act |=> host_bus_oe == LHB_OE_NONE)
        else $error("bus driven while deselected");
    chk_soft_reset: assert property (new_byte && is_reset |=> ctrl_init && !wr_valid)
        else $error("reset command not applied");
    chk_nop_quiet: assert property (new_byte && is_nop |=> !wr_valid && !ctrl_init)
        else $error("nop command had an effect");
    chk_status_low: assert property (rd_act && !pf.dc
        |=> host_bus_o == {$past(status_in), LHB_STAT_LOW})
        else $error("status read low bits not zero");
    chk_rd_release: assert property (!rd_act |=> host_bus_oe == LHB_OE_NONE)
        else $error("bus still driven after read");
    chk_init_float: assert property (!pf.init_n |=> host_bus_oe == LHB_OE_NONE)
        else $error("bus driven during init");
    chk_data_read: assert property (rd_act && pf.dc |=> host_bus_o == $past(rd_data_in))
        else $error("display read data mismatch");
    chk_wr_single: assert property (wr_valid |=> !wr_valid)
        else $error("write pulse longer than one cycle");
    chk_6800_rd_dir: assert property ((mode == LHB_M6800) && pf.wr |=> !wr_valid)
        else $error("6800 write taken in read direction");

endmodule : lhb_host_if

`default_nettype wire

// ===== logic/lhb_pkg.sv
// Shared constants and types for the LCD host bus interface.
// Assumes a single 125 MHz clock domain; all pins arrive asynchronously.
`default_nettype none

package lhb_pkg;

    // ------------------------------------------------------------
    // Bus modes
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        LHB_M8080 = 2'b00,
        LHB_M6800 = 2'b01,
        LHB_MSER = 2'b10
    } lhb_mode_type;

    // ------------------------------------------------------------
    // Pin bundle as sampled from the outside
    // ------------------------------------------------------------
    typedef struct packed {
        logic cs_n;
        logic cs_hi;
        logic init_n;
        logic dc;
        logic wr;
        logic rd;
        logic style;
        logic par;
        logic [7:0] bus;
    } lhb_pins_type;

    // Quiet bus: deselected, strobes idle, parallel 8080
    localparam logic [15:0] LHB_PINS_IDLE = 16'hAD00;

    // ------------------------------------------------------------
    // Command codes and field layout
    // ------------------------------------------------------------
    localparam logic [7:0] LHB_CMD_RESET = 8'hE2;
    localparam logic [7:0] LHB_CMD_NOP = 8'hE3;
    localparam int LHB_BUS_W = 8;
    localparam int LHB_STAT_LSB = 4;
    localparam logic [3:0] LHB_STAT_LOW = 4'h0;
    localparam int LHB_SCL_BIT = 6;
    localparam int LHB_SI_BIT = 7;
    localparam logic [2:0] LHB_SER_LAST = 3'h7;
    localparam logic [7:0] LHB_OE_ALL = 8'hFF;
    localparam logic [7:0] LHB_OE_NONE = 8'h00;
    localparam logic [7:0] LHB_BYTE_RST = 8'h00;

endpackage : lhb_pkg

`default_nettype wire

// ===== sim/lhb_host_model.sv
// Host processor model that drives the display bus pins.
// Assumes the bench owns clk and reset; the data lines are resolved here.
`default_nettype none

module lhb_host_model
    import lhb_pkg::*;
(
    // Clock
    input wire logic clk,
    // Device side of the data lines
    input wire logic [7:0] dev_o,
    input wire logic [7:0] dev_oe,
    // Pins as the device sees them
    output var lhb_pins_type pins,
    output wire logic [7:0] bus_seen
);
    timeunit 1ns;
    timeprecision 1ps;

    // Slow host: every phase held at least this many cycles
    int hold = 4;

    initial pins = lhb_pins_type'(LHB_PINS_IDLE);
    assign bus_seen = (dev_o & dev_oe) | (pins.bus & ~dev_oe);

    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : step

    // straps set only while held in reset
    task automatic strap(input logic style, input logic par);
        pins.style = style;
        pins.par = par;
        pins.rd = !style;
        pins.wr = 1'b1;
        // Quiet lines, else a stale high SCL reads as an edge after reset
        pins.bus = 8'h00;
    endtask : strap

    task automatic sel(input logic on, input logic init);
        pins.cs_n = !on;
        pins.cs_hi = on;
        pins.init_n = init;
        step(hold);
    endtask : sel

    // dc and data held across the strobe
    task automatic write(input logic dc, input logic [7:0] b);
        pins.dc = dc;
        pins.bus = b;
        pins.wr = 1'b0;
        // Read strobe idle in 8080, enable high in 6800
        pins.rd = 1'b1;
        step(hold);
        if (pins.style) begin
            pins.rd = 1'b0;
            step(hold);
        end
        pins.wr = 1'b1;
        step(hold + 2);
    endtask : write

    // read: released lines show the inverse of the last value
    task automatic read(input logic dc, output logic [7:0] got);
        pins.dc = dc;
        pins.bus = ~pins.bus;
        pins.wr = 1'b1;
        pins.rd = pins.style;
        step(hold + 3);
        got = bus_seen;
        pins.rd = !pins.style;
        step(hold + 2);
    endtask : read

    // Serial clock rests low outside the frame
    task automatic ser(input logic dc, input logic [7:0] b);
        pins.dc = dc;
        for (int i = 7; i >= 0; i--) begin
            pins.bus[LHB_SI_BIT] = b[i];
            pins.bus[LHB_SCL_BIT] = 1'b0;
            step(hold);
            pins.bus[LHB_SCL_BIT] = 1'b1;
            step(hold);
        end
        pins.bus[LHB_SCL_BIT] = 1'b0;
        step(hold + 2);
    endtask : ser
endmodule : lhb_host_model

`default_nettype wire

// ===== sim/lcd_host_bus_interface_test.sv
// Self-checking bench for the host bus port.
// Assumes a host model on the pins and the core side driven here.
`default_nettype none

module lcd_host_bus_interface_test
    import lhb_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [3:0] status_in = 4'h0;
    logic [7:0] rd_data_in = 8'h00;
    lhb_pins_type pins;
    logic [7:0] bus_seen, bus_o, bus_oe, wr_data, got;
    logic wr_valid, wr_is_data, rd_done, ctrl_init, oe_seen;
    int err_count = 0, checked = 0, wr_cnt = 0, init_cnt = 0, done_cnt = 0, c0, i0;

    lhb_host_model m (.clk(clk), .dev_o(bus_o), .dev_oe(bus_oe), .pins(pins),
        .bus_seen(bus_seen));
    lhb_host_if dut_u (.clk(clk), .sys_rst(sys_rst), .chip_sel_n(pins.cs_n),
        .chip_sel_hi(pins.cs_hi), .hw_init_n(pins.init_n), .data_cmd_sel(pins.dc),
        .wr_strobe_n(pins.wr), .rd_strobe_n(pins.rd), .bus_style_sel(pins.style),
        .par_ser_sel(pins.par), .host_bus_i(bus_seen), .host_bus_o(bus_o),
        .host_bus_oe(bus_oe), .status_in(status_in), .rd_data_in(rd_data_in),
        .wr_valid(wr_valid), .wr_data(wr_data), .wr_is_data(wr_is_data),
        .rd_done(rd_done), .ctrl_init(ctrl_init));

    initial forever #4 clk = ~clk;

    always @(posedge clk) begin
        if (wr_valid === 1'b1) wr_cnt++;
        if (ctrl_init === 1'b1) init_cnt++;
        if (rd_done === 1'b1) done_cnt++;
        if (bus_oe !== 8'h00) oe_seen = 1'b1;
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic give_verdict();
        $display("errors=%0d checks=%0d", err_count, checked);
        if (err_count == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : give_verdict

    task automatic set_mode(input logic style, input logic par);
        sys_rst = 1'b1;
        m.strap(style, par);
        m.step(3);
        sys_rst = 1'b0;
        m.sel(1'b1, 1'b1);
        c0 = wr_cnt;
        i0 = init_cnt;
        oe_seen = 1'b0;
    endtask : set_mode

    task automatic t_wr8080();
        set_mode(1'b0, 1'b1);
        m.write(1'b1, 8'hA5);
        check(16'(wr_cnt - c0), 16'h0001);
        check({wr_is_data, wr_data}, 16'h01A5);
        m.write(1'b0, 8'h3C);
        check({wr_is_data, wr_data}, 16'h003C);
    endtask : t_wr8080

    task automatic t_cmds();
        set_mode(1'b0, 1'b1);
        m.write(1'b0, LHB_CMD_RESET);
        check(16'(init_cnt - i0), 16'h0001);
        m.write(1'b0, LHB_CMD_NOP);
        check(16'(init_cnt - i0), 16'h0001);
        check(16'(wr_cnt - c0), 16'h0000);
    endtask : t_cmds

    task automatic t_desel();
        set_mode(1'b0, 1'b1);
        m.sel(1'b0, 1'b1);
        m.write(1'b1, 8'h11);
        m.read(1'b1, got);
        check(16'(wr_cnt - c0), 16'h0000);
        check(16'(oe_seen), 16'h0000);
    endtask : t_desel

    task automatic t_read(input logic style);
        set_mode(style, 1'b1);
        rd_data_in = 8'h5A;
        m.read(1'b1, got);
        check({8'(done_cnt), got}, 16'h015A);
        status_in = 4'h9;
        m.read(1'b0, got);
        check(16'(got), 16'h0090);
        m.write(1'b1, 8'hC7);
        check({8'(wr_cnt - c0), wr_data}, 16'h01C7);
        done_cnt = 0;
    endtask : t_read

    task automatic t_serial();
        set_mode(1'b0, 1'b0);
        m.ser(1'b1, 8'hC3);
        check({wr_is_data, wr_data}, 16'h01C3);
        m.ser(1'b0, 8'h2D);
        check({8'(wr_cnt - c0), wr_data}, 16'h022D);
        check(16'(oe_seen), 16'h0000);
    endtask : t_serial

    task automatic t_init();
        set_mode(1'b0, 1'b1);
        m.sel(1'b1, 1'b0);
        m.step(2);
        check(16'(ctrl_init), 16'h0001);
        m.write(1'b1, 8'h77);
        check(16'(wr_cnt - c0), 16'h0000);
        m.sel(1'b1, 1'b1);
    endtask : t_init

    initial begin
        #100000;
        err_count++;
        give_verdict();
    end

    initial begin
        #1;
        t_wr8080();
        t_cmds();
        t_desel();
        // 8080 read strobe, then 6800 enable strobe on the read pin
        t_read(1'b0);
        t_read(1'b1);
        t_serial();
        t_init();
        give_verdict();
    end
endmodule : lcd_host_bus_interface_test

`default_nettype wire
